// ### eight_bit_ir_timer.sv
// Eight-bit IR transmit and demodulation timer with an APB register port.
//
// Overview of operation
// - Edge detector watches selected input, emits rise or fall pulse per edge select.
// - Pulses narrower than the glitch filter setting are discarded.
// - While disabled, timer output shows inverse of initial-value bit.
// - On enable output takes initial value; load low or high reload accordingly.
// - Single-pass counts to zero, stops, toggles output, sets timeout, interrupts.
// - Modulo-N first terminal count toggles output without interrupt.
// - Modulo-N reloads per output level, toggles, sets timeout, repeats forever.
// - Reload registers writable anytime; new value used at next reload.
// - Reload of zero wraps through FFh; reload of one is unsupported.
// - Wrap from zero to FFh is no timeout.
// - Demodulation expects FFh reloads; counting starts at first selected edge.
// - Later edges capture complemented count into rise or fall capture.
// - Capture sets edge flag, may interrupt, reloads FFh and counts on.
// - Demodulation zero sets timeout, may interrupt, continues from FFh.
// - Timeout status clears only by writing one to it.
// - Writing enable one starts, zero stops; reading returns running state.
`timescale 1ns/1ps

module eight_bit_ir_timer
  import ir_timer_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        edge_input_a,
  input  wire logic        edge_input_b,
  output logic             timer_output,
  output logic             timer_output_en,
  output logic             irq
);
  import ir_timer_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_COUNT, ST_DONE} run_state_t;

  typedef struct packed {
    logic [7:0]       main_ctrl;
    logic [7:0]       mode_ctrl;
    logic [3:0]       div_sel;
    logic             enable;
    logic [7:0]       high_reload;
    logic [7:0]       low_reload;
    logic [7:0]       rise_cap;
    logic [7:0]       fall_cap;
    logic [7:0]       count;
    logic             tout;
    logic             first_tc;
    run_state_t       run;
    logic [DIV_W-1:0] div_cnt;
    logic             filt_level;
    logic [5:0]       filt_cnt;
    logic             irq;
    logic [31:0]      rdata;
    logic             ready;
    logic             slverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic             access;
  logic             wr;
  logic             tick;
  logic             raw_in;
  logic [5:0]       filt_min;
  logic             new_level;
  logic             rise_p;
  logic             fall_p;
  logic             sel_edge;
  logic [1:0]       esel;
  logic [31:0]      rd_mux;

  always_comb begin
    s_d = s_q;

    // ****************************************************************
    // Bus access
    // ****************************************************************
    // Pready is registered, so every access carries one wait state.
    access = psel && penable && !s_q.ready;
    // A write lands at the edge where the master sees pready, never earlier.
    wr = psel && penable && s_q.ready && pwrite;
    s_d.ready = access;
    s_d.slverr = 1'b0;
    tick = (s_q.div_cnt == DIV_W'(s_q.div_sel));
    s_d.div_cnt = tick ? '0 : s_q.div_cnt + DIV_W'(1);

    // ****************************************************************
    // Input pin, glitch filter and edge detection
    // ****************************************************************
    // pin select.
    raw_in = s_q.mode_ctrl[MODE_PIN_SEL_BIT] ? edge_input_b : edge_input_a;
    filt_min = 6'(s_q.mode_ctrl[MODE_FILT_HI:MODE_FILT_LO]) * 6'(FILTER_STEP);
    new_level = s_q.filt_level;
    if (raw_in == s_q.filt_level) begin
      s_d.filt_cnt = '0;
    end else if (s_q.filt_cnt + 6'd1 >= filt_min) begin
      // The new level is taken once it has lasted the full minimum width.
      new_level = raw_in;
      s_d.filt_cnt = '0;
    end else begin
      s_d.filt_cnt = s_q.filt_cnt + 6'd1;
    end
    s_d.filt_level = new_level;
    esel = s_q.mode_ctrl[MODE_EDGE_HI:MODE_EDGE_LO];
    rise_p = new_level && !s_q.filt_level && (esel == EDGE_RISE || esel == EDGE_BOTH);
    fall_p = !new_level && s_q.filt_level && (esel == EDGE_FALL || esel == EDGE_BOTH);
    sel_edge = rise_p || fall_p;

    // ****************************************************************
    // Timer engine
    // ****************************************************************
    if (!s_q.enable) begin
      s_d.run = ST_IDLE;
      s_d.tout = ~s_q.mode_ctrl[MODE_INIT_BIT];
    end else begin
      case (s_q.run)
        ST_IDLE: begin
          s_d.tout = s_q.mode_ctrl[MODE_INIT_BIT];
          s_d.count = s_q.mode_ctrl[MODE_INIT_BIT] ? s_q.high_reload : s_q.low_reload;
          s_d.first_tc = 1'b1;
          s_d.run = s_q.mode_ctrl[MODE_DEMOD_BIT] ? ST_WAIT_EDGE : ST_COUNT;
        end
        ST_WAIT_EDGE: begin
          if (sel_edge) begin
            s_d.count = COUNT_MAX;
            s_d.run = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (s_q.mode_ctrl[MODE_DEMOD_BIT]) begin
            if (sel_edge) begin
              if (rise_p) begin
                s_d.rise_cap = ~s_q.count;
                s_d.mode_ctrl[MODE_RISE_FLAG_BIT] = 1'b1;
              end else begin
                s_d.fall_cap = ~s_q.count;
                s_d.mode_ctrl[MODE_FALL_FLAG_BIT] = 1'b1;
              end
              s_d.count = COUNT_MAX;
            end else if (tick) begin
              if (s_q.count == 8'h01) begin
                s_d.main_ctrl[MAIN_TIMEOUT_BIT] = 1'b1;
              end
              s_d.count = s_q.count - 8'd1;
            end
          end else if (tick) begin
            if (s_q.count == 8'h01) begin
              s_d.tout = ~s_q.tout;
              s_d.first_tc = 1'b0;
              if (s_q.main_ctrl[MAIN_SINGLE_BIT]) begin
                s_d.main_ctrl[MAIN_TIMEOUT_BIT] = 1'b1;
                s_d.count = '0;
                s_d.run = ST_DONE;
              end else begin
                if (!s_q.first_tc) begin
                  s_d.main_ctrl[MAIN_TIMEOUT_BIT] = 1'b1;
                end
                s_d.count = s_q.tout ? s_q.low_reload : s_q.high_reload;
              end
            end else begin
              s_d.count = s_q.count - 8'd1;
            end
          end
        end
        ST_DONE: begin
          // Clearing enable lets software read back that the single pass is over.
          s_d.enable = 1'b0;
        end
        default: s_d.run = ST_IDLE;
      endcase
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Hardware set beats software clear, except a timeout arriving while the timeout flag is already set.
    if (wr) begin
      case (paddr)
        OFF_MAIN_CTRL: begin
          s_d.main_ctrl[7:6] = pwdata[7:6];
          s_d.main_ctrl[4:0] = pwdata[4:0];
          if (pwdata[MAIN_TIMEOUT_BIT] && !(s_d.main_ctrl[MAIN_TIMEOUT_BIT] && !s_q.main_ctrl[MAIN_TIMEOUT_BIT])) begin
            s_d.main_ctrl[MAIN_TIMEOUT_BIT] = 1'b0;
          end
        end
        OFF_MODE_CTRL: begin
          s_d.mode_ctrl[7:2] = pwdata[7:2];
          if (s_q.mode_ctrl[MODE_DEMOD_BIT]) begin
            if (pwdata[MODE_RISE_FLAG_BIT] && !(rise_p && s_q.run == ST_COUNT)) begin
              s_d.mode_ctrl[MODE_RISE_FLAG_BIT] = 1'b0;
            end
            if (pwdata[MODE_FALL_FLAG_BIT] && !(fall_p && s_q.run == ST_COUNT)) begin
              s_d.mode_ctrl[MODE_FALL_FLAG_BIT] = 1'b0;
            end
          end else begin
            s_d.mode_ctrl[1:0] = pwdata[1:0];
          end
        end
        OFF_TIMER_CTRL: begin
          s_d.enable = pwdata[TCTRL_ENABLE_BIT];
          s_d.div_sel = pwdata[TCTRL_DIV_HI:TCTRL_DIV_LO];
        end
        OFF_HIGH_RELOAD: s_d.high_reload = pwdata[7:0];
        OFF_LOW_RELOAD: s_d.low_reload = pwdata[7:0];
        // Capture and count are read only; the error flag was decided at the access.
        default: ;
      endcase
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    rd_mux = '0;
    case (paddr)
      OFF_MAIN_CTRL: rd_mux = {24'h0000_00, s_q.main_ctrl};
      OFF_MODE_CTRL: rd_mux = {24'h0000_00, s_q.mode_ctrl};
      OFF_TIMER_CTRL: rd_mux = {24'h0000_00, s_q.div_sel, 3'b000, s_q.enable};
      OFF_HIGH_RELOAD: rd_mux = {24'h0000_00, s_q.high_reload};
      OFF_LOW_RELOAD: rd_mux = {24'h0000_00, s_q.low_reload};
      OFF_RISE_CAPTURE: rd_mux = {24'h0000_00, s_q.rise_cap};
      OFF_FALL_CAPTURE: rd_mux = {24'h0000_00, s_q.fall_cap};
      OFF_COUNT: rd_mux = {24'h0000_00, s_q.count};
      default: rd_mux = '0;
    endcase
    // Writes land one edge after the access is taken, so the error flag for both directions is set here.
    if (access) begin
      if (!pwrite) begin
        s_d.rdata = rd_mux;
      end
      case (paddr)
        OFF_MAIN_CTRL, OFF_MODE_CTRL, OFF_TIMER_CTRL, OFF_HIGH_RELOAD,
        OFF_LOW_RELOAD, OFF_RISE_CAPTURE, OFF_FALL_CAPTURE, OFF_COUNT: s_d.slverr = 1'b0;
        default: s_d.slverr = 1'b1;
      endcase
    end

    // ****************************************************************
    // Interrupt request
    // ****************************************************************
    // Interrupt request follows sticky status gated by enables.
    s_d.irq = (s_d.main_ctrl[MAIN_TIMEOUT_BIT] && s_d.main_ctrl[MAIN_TIMEOUT_IE_BIT]) ||
              (s_d.mode_ctrl[MODE_DEMOD_BIT] && s_d.main_ctrl[MAIN_EDGE_IE_BIT] &&
               (s_d.mode_ctrl[MODE_RISE_FLAG_BIT] || s_d.mode_ctrl[MODE_FALL_FLAG_BIT]));
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      // The output rests high, the idle level for a cleared initial-value bit.
      s_q.tout <= 1'b1;
      s_q.run <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready = s_q.ready;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;
  assign timer_output = s_q.tout;
  assign timer_output_en = s_q.main_ctrl[MAIN_OUT_EN_BIT];
  assign irq = s_q.irq;

endmodule : eight_bit_ir_timer

// ### ir_timer_pkg.sv
// Package with register map, field positions and reset values of the eight-bit IR timer.
package ir_timer_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h04;
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h08;
  localparam logic [7:0] OFF_HIGH_RELOAD = 8'h0C;
  localparam logic [7:0] OFF_LOW_RELOAD = 8'h10;
  localparam logic [7:0] OFF_RISE_CAPTURE = 8'h14;
  localparam logic [7:0] OFF_FALL_CAPTURE = 8'h18;
  localparam logic [7:0] OFF_COUNT = 8'h1C;

  // ****************************************************************
  // Main control fields
  // ****************************************************************
  localparam int MAIN_SINGLE_BIT = 6;
  localparam int MAIN_TIMEOUT_BIT = 5;
  localparam int MAIN_EDGE_IE_BIT = 2;
  localparam int MAIN_TIMEOUT_IE_BIT = 1;
  localparam int MAIN_OUT_EN_BIT = 0;

  // ****************************************************************
  // Mode control fields
  // ****************************************************************
  localparam int MODE_DEMOD_BIT = 7;
  localparam int MODE_PIN_SEL_BIT = 6;
  localparam int MODE_EDGE_HI = 5;
  localparam int MODE_EDGE_LO = 4;
  localparam int MODE_FILT_HI = 3;
  localparam int MODE_FILT_LO = 2;
  localparam int MODE_INIT_BIT = 1;
  localparam int MODE_FALL_FLAG_BIT = 0;
  localparam int MODE_RISE_FLAG_BIT = 1;

  // ****************************************************************
  // Timer control fields and edge selections
  // ****************************************************************
  localparam int TCTRL_ENABLE_BIT = 0;
  localparam int TCTRL_DIV_HI = 7;
  localparam int TCTRL_DIV_LO = 4;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ****************************************************************
  // Constants and reset values
  // ****************************************************************
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] FILTER_STEP = 4'h4;

endpackage : ir_timer_pkg

// ### ir_timer_checker.sv
// Concurrent assertions on the ports of the eight-bit IR timer.
`timescale 1ns/1ps
module ir_timer_checker
  import ir_timer_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        edge_input_a,
  input wire logic        edge_input_b,
  input wire logic        timer_output,
  input wire logic        timer_output_en,
  input wire logic        irq
);
  logic take, wr, init_q, demod_q, en_q, ie_q;
  assign take = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  // Shadow control bits; single pass clears enable itself, so en_q only marks software stops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b0;
      demod_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
    end else if (wr) begin
      if (paddr == OFF_MODE_CTRL) begin
        init_q <= pwdata[MODE_INIT_BIT];
        demod_q <= pwdata[MODE_DEMOD_BIT];
      end
      if (paddr == OFF_TIMER_CTRL) begin
        en_q <= pwdata[TCTRL_ENABLE_BIT];
      end
      if (paddr == OFF_MAIN_CTRL) begin
        ie_q <= pwdata[MAIN_EDGE_IE_BIT] | pwdata[MAIN_TIMEOUT_IE_BIT];
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_idle;
    (!en_q && !demod_q && $stable(init_q)) [*6];
  endsequence
  a_ready_follows: assert property (take |=> pready) else $error("pready missing");
  a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
  a_err_unmapped: assert property (take && paddr > OFF_COUNT |=> pslverr) else $error("pslverr missing");
  a_idle_level: assert property (s_idle |-> timer_output == !init_q)
    else $error("idle level wrong");
  a_enable_level: assert property ($rose(en_q) && !demod_q |-> ##[1:3] timer_output == init_q)
    else $error("enable level wrong");
  a_oe_follows: assert property (wr && paddr == OFF_MAIN_CTRL |=> timer_output_en == $past(pwdata[0]))
    else $error("output enable wrong");
  a_irq_enabled: assert property (irq |-> ie_q || $past(ie_q))
    else $error("irq while masked");
endmodule : ir_timer_checker

// ### ir_pulse_source.sv
// Behavioural source of the pulse train on the two edge inputs.
`timescale 1ns/1ps
module ir_pulse_source (
  input  wire logic pclk,
  output logic      edge_input_a,
  output logic      edge_input_b
);
  initial begin
    edge_input_a = 1'b0;
    edge_input_b = 1'b0;
  end
  // The unused line keeps changing, so a wrong pin choice shows as stray edges.
  always @(posedge pclk) edge_input_b <= ~edge_input_b;
  task automatic drive(input logic level, input int hold);
    @(posedge pclk);
    edge_input_a <= level;
    repeat (hold - 1) @(posedge pclk);
  endtask : drive
endmodule : ir_pulse_source

// ### testbench.sv
// Self-checking testbench of the eight-bit IR timer.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module testbench;
  import ir_timer_pkg::*;
  typedef struct packed {logic err; logic [31:0] data; logic [31:0] mask;} note_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, timer_output, timer_output_en, irq, edge_input_a, edge_input_b, prev_out;
  note_t       notes[$], n;
  int          errors = 0, total_checks = 0, run_len = 0, phase_len = 0, toggles = 0, t0, lo, hi;
  always #12.5 pclk = ~pclk;
  eight_bit_ir_timer #(.DIV_W(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .edge_input_a(edge_input_a), .edge_input_b(edge_input_b), .timer_output(timer_output),
    .timer_output_en(timer_output_en), .irq(irq));
  ir_pulse_source src (.pclk(pclk), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b));
  always @(posedge pclk) begin
    prev_out <= timer_output;
    run_len <= (timer_output !== prev_out) ? 1 : run_len + 1;
    if (timer_output !== prev_out) begin
      phase_len <= run_len;
      toggles <= toggles + 1;
    end
    if (psel && penable && pready) begin
      n = notes.pop_front();
      `CHK("pslverr", n.err, pslverr)
      `CHK("prdata", n.data, prdata & n.mask)
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hFFFF_FFFF, input logic err = 1'b0);
    @(posedge pclk);
    notes.push_back('{err, wr ? 32'h0000_0000 : d & m, wr ? 32'h0000_0000 : m});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_tog(input int k);
    int w;
    w = 0;
    while (toggles < k && w < 3000) begin
      @(negedge pclk);
      w++;
    end
    if (w >= 3000) begin
      errors++;
    end
  endtask : wait_tog
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #2_000_000;
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(27760));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("idle output", 1'b1, timer_output)
    for (int a = 0; a <= 8'h1C; a += 4) begin
      apb(1'b0, a[7:0], 32'h0000_0000);
    end
    apb(1'b0, 8'h20, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    $display("Reset test done");
    t0 = $urandom;
    apb(1'b1, OFF_HIGH_RELOAD, t0);
    apb(1'b0, OFF_HIGH_RELOAD, {24'h00_0000, t0[7:0]});
    apb(1'b1, OFF_RISE_CAPTURE, 32'h0000_00FF);
    apb(1'b0, OFF_RISE_CAPTURE, 32'h0000_0000);
    $display("Register test done");
    lo = 2 + $urandom % 6;
    hi = 2 + $urandom % 6;
    apb(1'b1, OFF_LOW_RELOAD, lo);
    apb(1'b1, OFF_HIGH_RELOAD, hi);
    apb(1'b1, OFF_MAIN_CTRL, 32'h0000_0003);
    t0 = toggles;
    apb(1'b1, OFF_TIMER_CTRL, 32'h0000_0011);
    wait_tog(t0 + 2);
    `CHK("first terminal irq", 1'b0, irq)
    wait_tog(t0 + 3);
    `CHK("high phase", 2 * hi, phase_len)
    `CHK("timeout irq", 1'b1, irq)
    wait_tog(t0 + 4);
    `CHK("low phase", 2 * lo, phase_len)
    apb(1'b0, OFF_TIMER_CTRL, 32'h0000_0011);
    apb(1'b0, OFF_MAIN_CTRL, 32'h0000_0020, 32'h0000_0020);
    apb(1'b1, OFF_TIMER_CTRL, 32'h0000_0000);
    apb(1'b1, OFF_MAIN_CTRL, 32'h0000_0023);
    apb(1'b0, OFF_MAIN_CTRL, 32'h0000_0003);
    $display("Modulo test done");
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_0002);
    apb(1'b1, OFF_MAIN_CTRL, 32'h0000_0043);
    t0 = toggles;
    apb(1'b1, OFF_TIMER_CTRL, 32'h0000_0011);
    wait_tog(t0 + 2);
    `CHK("single irq", 1'b1, irq)
    repeat (40) @(negedge pclk);
    `CHK("single stop", t0 + 2, toggles)
    apb(1'b0, OFF_TIMER_CTRL, 32'h0000_0010);
    apb(1'b0, OFF_MAIN_CTRL, 32'h0000_0063);
    apb(1'b1, OFF_MAIN_CTRL, 32'h0000_0020);
    $display("Single pass test done");
    apb(1'b1, OFF_TIMER_CTRL, 32'h0000_0000);
    apb(1'b1, OFF_LOW_RELOAD, 32'h0000_00FF);
    apb(1'b1, OFF_HIGH_RELOAD, 32'h0000_00FF);
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_00B0);
    apb(1'b1, OFF_MAIN_CTRL, 32'h0000_0004);
    apb(1'b1, OFF_TIMER_CTRL, 32'h0000_0001);
    src.drive(1'b1, 8'h28);
    src.drive(1'b0, 8'h48);
    src.drive(1'b1, 4);
    apb(1'b0, OFF_FALL_CAPTURE, 32'h0000_0020, 32'h0000_00F0);
    apb(1'b0, OFF_RISE_CAPTURE, 32'h0000_0040, 32'h0000_00F0);
    apb(1'b0, OFF_MODE_CTRL, 32'h0000_00B3);
    `CHK("edge irq", 1'b1, irq)
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_00BF);
    src.drive(1'b0, 4);
    src.drive(1'b1, 20);
    apb(1'b0, OFF_MODE_CTRL, 32'h0000_00BC);
    src.drive(1'b0, 12);
    src.drive(1'b1, 20);
    apb(1'b0, OFF_MODE_CTRL, 32'h0000_00BF);
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_0093);
    src.drive(1'b0, 8);
    src.drive(1'b1, 8);
    apb(1'b0, OFF_MODE_CTRL, 32'h0000_0092);
    repeat (600) @(posedge pclk);
    apb(1'b0, OFF_MAIN_CTRL, 32'h0000_0020, 32'h0000_0020);
    $display("Demodulation test done");
    final_report();
  end
endmodule : testbench
bind eight_bit_ir_timer ir_timer_checker #(.DIV_W(DIV_W)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b), .timer_output(timer_output),
  .timer_output_en(timer_output_en), .irq(irq));
